// File: design/tpd_pkg.sv
// Purpose: Constants shared by the timer PWM duty generator.
// Assumes: Byte-wide register port with offsets as printed.
// Notes on behaviour
// - Output goes low when the count equals the duty compare value.
// - Duty compare register, 8 bits, read/write, at 0xea, resets to zero.
// - Pin carries PWM only when timer enable and PWM enable are both set.
// - Each PWM cycle with duty above reload starts high and drops low later; otherwise the output stays low.
// - Count loads from reload on enable and on every overflow.
// - Overflow at 0xff reloads the count and ends the cycle; output returns high if duty is above the new reload.
// - A new period takes effect only from the next reload.
// - Overflow flag and interrupt request still work while PWM runs.
// - PWM enable steers the pin; clearing it restores GPIO, timer keeps running.
// - Any 8-bit reload is accepted; 0x00 gives 256 counts per cycle.
// - Overflow sets a sticky flag that stays until software clears it.
// - Source 0 counts instruction clock over 128 down to 1; source 1 counts oscillator.
// - Reload writes are staged and moved to the active buffer at overflow.
package tpd_pkg;
  localparam logic [7:0] ADDR_MODE   = 8'hdc;
  localparam logic [7:0] ADDR_COUNT  = 8'hdd;
  localparam logic [7:0] ADDR_RELOAD = 8'hde;
  localparam logic [7:0] ADDR_DUTY   = 8'hea;
  localparam logic [7:0] ADDR_STATUS = 8'hdf;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] CNT_FULL    = 8'hff;
  localparam int         BIT_PWM_EN  = 0;
  localparam int         BIT_SRC     = 2;
  localparam int         BIT_RATE_LO = 4;
  localparam int         BIT_TMR_EN  = 7;
  localparam int         BIT_FLAG    = 0;
  localparam int         BIT_IRQ_EN  = 1;
  localparam logic [7:0] MODE_MASK   = 8'hf5;
  localparam logic [6:0] PRE_ONES    = 7'h7f;
endpackage : tpd_pkg

// File: design/tpd_prescale.sv
// Purpose: Count-tick generator selecting divided instruction clock or oscillator.
// Assumes: Both clock sources arrive as one-cycle enable pulses on core_clk_in.
// Notes: The divider free-runs so a rate change takes effect within one period.
`timescale 1ns/100ps
module tpd_prescale (
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       cpu_tick_in,
  input  wire logic       osc_tick_in,
  input  wire logic       src_sel_in,
  input  wire logic [2:0] rate_in,
  output logic            tick_out
);
  logic [6:0] div_r;
  logic [6:0] div_nxt;
  logic [6:0] div_mask;
  logic       div_hit;

  assign div_nxt  = cpu_tick_in ? div_r + 7'h01 : div_r;
  // Rate 000 divides by 128, each step halves, 111 divides by 1.
  assign div_mask = tpd_pkg::PRE_ONES >> rate_in;
  assign div_hit  = cpu_tick_in && ((div_r & div_mask) == div_mask);
  assign tick_out = src_sel_in ? osc_tick_in : div_hit;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      div_r <= 7'h00;
    end else begin
      div_r <= div_nxt;
    end
  end

  div_tick_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!src_sel_in && rate_in == 3'h7 && cpu_tick_in) |-> tick_out)
    else $error("Divide-by-one did not tick on the instruction clock.");
endmodule : tpd_prescale

// File: design/tpd_pwm_out.sv
// Purpose: PWM level and shared pin steering.
// Assumes: Count advance and overflow pulses come from the timer core.
// Notes: Pin returns to the GPIO value the moment PWM enable drops.
`timescale 1ns/100ps
module tpd_pwm_out (
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       tmr_en_in,
  input  wire logic       pwm_en_in,
  input  wire logic       start_in,
  input  wire logic       ovf_in,
  input  wire logic       step_in,
  input  wire logic [7:0] count_nxt_in,
  input  wire logic [7:0] duty_in,
  input  wire logic [7:0] reload_in,
  input  wire logic       gpio_out_in,
  input  wire logic       gpio_oe_in,
  output logic            pin_out,
  output logic            pin_oe_out
);
  logic pwm_r;
  logic pwm_nxt;
  logic duty_ok;

  // Duty at or below the reload value never exceeds the count start.
  assign duty_ok = duty_in > reload_in;
  always_comb begin
    pwm_nxt = pwm_r;
    if (!tmr_en_in) begin
      pwm_nxt = 1'b0;
    end else if ((start_in || ovf_in) && duty_ok) begin
      pwm_nxt = 1'b1;
    end else if (!duty_ok) begin
      pwm_nxt = 1'b0;
    end else if (step_in && count_nxt_in == duty_in) begin
      pwm_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= pwm_nxt;
    end
  end

  assign pin_out    = pwm_en_in ? (pwm_r & tmr_en_in) : gpio_out_in;
  assign pin_oe_out = pwm_en_in ? 1'b1 : gpio_oe_in;

  pin_gpio_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !pwm_en_in |-> (pin_out == gpio_out_in && pin_oe_out == gpio_oe_in))
    else $error("Pin not returned to GPIO with PWM disabled.");
  pwm_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (pwm_en_in && !tmr_en_in) |-> !pin_out)
    else $error("PWM pin high while timer disabled.");
  low_duty_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (tmr_en_in && !duty_ok) |=> !pwm_r)
    else $error("PWM high with duty not above reload.");
endmodule : tpd_pwm_out

// File: design/tpd_timer.sv
// Purpose: 8-bit auto-reload timer with PWM duty output and register port.
// Assumes: Register strobes are single-cycle; read data valid the next cycle.
// Notes: The interrupt request is a level equal to flag and enable.
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
module tpd_timer (
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       cpu_tick_in,
  input  wire logic       osc_tick_in,
  input  wire logic       gpio_out_in,
  input  wire logic       gpio_oe_in,
  output logic            pin_out,
  output logic            pin_oe_out,
  output logic            irq_out
);
  logic [7:0] mode_r;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] stage_r;
  logic [7:0] reload_r;
  logic [7:0] duty_r;
  logic       flag_r;
  logic       flag_nxt;
  logic       irq_en_r;
  logic       en_d_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       tick;
  logic       tmr_en;
  logic       start;
  logic       ovf;
  logic       step;
  logic       wr_mode;
  logic       wr_count;
  logic       wr_reload;
  logic       wr_duty;
  logic       wr_status;
  logic [7:0] cyc_reload;

  assign wr_mode   = wr_in && addr_in == tpd_pkg::ADDR_MODE;
  assign wr_count  = wr_in && addr_in == tpd_pkg::ADDR_COUNT;
  assign wr_reload = wr_in && addr_in == tpd_pkg::ADDR_RELOAD;
  assign wr_duty   = wr_in && addr_in == tpd_pkg::ADDR_DUTY;
  assign wr_status = wr_in && addr_in == tpd_pkg::ADDR_STATUS;

  assign tmr_en = mode_r[tpd_pkg::BIT_TMR_EN];
  // Enable rising edge reloads the count from the active reload buffer.
  assign start  = tmr_en && !en_d_r;
  assign step   = tmr_en && tick && !start;
  assign ovf    = step && count_r == tpd_pkg::CNT_FULL;
  // The duty test must see the reload that starts the coming cycle, not the old one.
  assign cyc_reload = ovf ? stage_r : reload_r;

  tpd_prescale u_pre (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .cpu_tick_in (cpu_tick_in),
    .osc_tick_in (osc_tick_in),
    .src_sel_in  (mode_r[tpd_pkg::BIT_SRC]),
    .rate_in     (mode_r[tpd_pkg::BIT_RATE_LO +: 3]),
    .tick_out    (tick)
  );

  always_comb begin
    count_nxt = count_r;
    if (wr_count) begin
      count_nxt = wdata_in;
    end else if (start) begin
      count_nxt = reload_r;
    end else if (ovf) begin
      // Overflow reloads from the staged value so a new period starts now.
      count_nxt = stage_r;
    end else if (step) begin
      count_nxt = count_r + 8'h01;
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  assign flag_nxt = ovf ? 1'b1 :
                    (wr_status && !wdata_in[tpd_pkg::BIT_FLAG]) ? 1'b0 : flag_r;

  always_comb begin
    case (addr_in)
      tpd_pkg::ADDR_MODE:   rdata_nxt = mode_r;
      tpd_pkg::ADDR_COUNT:  rdata_nxt = count_r;
      tpd_pkg::ADDR_DUTY:   rdata_nxt = duty_r;
      tpd_pkg::ADDR_STATUS: rdata_nxt = {6'h00, irq_en_r, flag_r};
      default:              rdata_nxt = tpd_pkg::RST_BYTE;
    endcase
    if (!rd_in) begin
      rdata_nxt = tpd_pkg::RST_BYTE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      mode_r   <= 8'h00;
      count_r  <= 8'h00;
      stage_r  <= 8'h00;
      reload_r <= 8'h00;
      duty_r   <= 8'h00;
      flag_r   <= 1'b0;
      irq_en_r <= 1'b0;
      en_d_r   <= 1'b0;
      rdata_r  <= 8'h00;
    end else begin
      if (wr_mode) begin
        mode_r <= wdata_in & tpd_pkg::MODE_MASK;
      end
      if (wr_reload) begin
        stage_r <= wdata_in;
      end
      if (ovf) begin
        reload_r <= stage_r;
      end else if (!tmr_en) begin
        // While stopped the two buffers track, so the first enable uses the write.
        reload_r <= stage_r;
      end
      if (wr_duty) begin
        duty_r <= wdata_in;
      end
      if (wr_status) begin
        irq_en_r <= wdata_in[tpd_pkg::BIT_IRQ_EN];
      end
      count_r <= count_nxt;
      flag_r  <= flag_nxt;
      en_d_r  <= tmr_en;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_out = rdata_r;
  assign irq_out   = flag_r && irq_en_r;

  tpd_pwm_out u_pwm (
    .core_clk_in  (core_clk_in),
    .rst_n_in     (rst_n_in),
    .tmr_en_in    (tmr_en),
    .pwm_en_in    (mode_r[tpd_pkg::BIT_PWM_EN]),
    .start_in     (start),
    .ovf_in       (ovf),
    .step_in      (step),
    .count_nxt_in (count_nxt),
    .duty_in      (duty_r),
    .reload_in    (cyc_reload),
    .gpio_out_in  (gpio_out_in),
    .gpio_oe_in   (gpio_oe_in),
    .pin_out      (pin_out),
    .pin_oe_out   (pin_oe_out)
  );

  ovf_flag_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ovf |=> flag_r)
    else $error("Overflow did not set the flag.");
  flag_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (flag_r && !wr_status) |=> flag_r)
    else $error("Flag dropped without a software clear.");
  ovf_reload_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (ovf && !wr_count) |=> count_r == $past(stage_r))
    else $error("Count not reloaded at overflow.");
  stop_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!tmr_en && !wr_count) |=> count_r == $past(count_r))
    else $error("Count moved while timer disabled.");
  stage_move_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (tmr_en && !ovf) |=> reload_r == $past(reload_r))
    else $error("Active reload changed without overflow.");
  duty_read_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (rd_in && addr_in == tpd_pkg::ADDR_DUTY) |=> rdata_out == $past(duty_r))
    else $error("Duty compare read back wrong.");
  irq_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (ovf && irq_en_r && !wr_status) |=> irq_out)
    else $error("Interrupt request missing.");
endmodule : tpd_timer

// File: dv/tpd_pin_load.sv
// Purpose: Load on the shared pin that times PWM high and period lengths.
// Assumes: The line has a pull-down, so a released pin reads low.
// Notes: Lengths are in core clock cycles, taken between pin edges.
`timescale 1ns/100ps
module tpd_pin_load (
  input  wire logic core_clk_in,
  input  wire logic pin_in,
  input  wire logic pin_oe_in,
  output int        high_cyc_out,
  output int        period_cyc_out,
  output int        rises_out
);
  logic line;
  logic line_q = 1'b0;
  int   cyc    = 0;
  int   t_rise = 0;
  assign line = pin_oe_in & pin_in;
  always @(posedge core_clk_in) begin
    cyc    <= cyc + 1;
    line_q <= line;
    if (line && !line_q) begin
      period_cyc_out <= cyc - t_rise;
      t_rise         <= cyc;
      rises_out      <= rises_out + 1;
    end
    if (!line && line_q) high_cyc_out <= cyc - t_rise;
  end
endmodule : tpd_pin_load

// File: dv/tpd_timer_tb_top.sv
// Purpose: Register-driven regression of the timer PWM block.
// Assumes: Both tick inputs pulse every cycle, so one tick is one cycle.
// Notes: Periods are read from the pin load, never from the design.
`timescale 1ns/100ps
module tpd_timer_tb_top;
  logic       core_clk_in = 1'b0;
  logic       rst_n_in    = 1'b0;
  logic [7:0] addr_in     = 8'h00;
  logic [7:0] wdata_in    = 8'h00;
  logic       wr_in       = 1'b0;
  logic       rd_in       = 1'b0;
  logic       gpio_out_in = 1'b1;
  logic       gpio_oe_in  = 1'b0;
  logic [7:0] rdata_out;
  logic       pin_out;
  logic       pin_oe_out;
  logic       irq_out;
  logic [7:0] d;
  logic [7:0] e;
  int         n_errors    = 0;
  int         num_checks  = 0;
  int         cycles      = 0;
  int         hi;
  int         per;
  int         rises;
  tpd_timer uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .cpu_tick_in(1'b1), .osc_tick_in(1'b1), .gpio_out_in(gpio_out_in),
    .gpio_oe_in(gpio_oe_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .irq_out(irq_out));
  tpd_pin_load load (.core_clk_in(core_clk_in), .pin_in(pin_out), .pin_oe_in(pin_oe_out),
    .high_cyc_out(hi), .period_cyc_out(per), .rises_out(rises));
  initial begin
    forever #25 core_clk_in = ~core_clk_in;
  end
  task automatic fail(input string n, input int x, input int g);
    n_errors++;
    $display("FAIL %s expected %0h seen %0h", n, x, g);
  endtask : fail
  task automatic chk_reg(input string n, input logic [7:0] x, input logic [7:0] g);
    num_checks++;
    if (g !== x) fail(n, x, g);
  endtask : chk_reg
  task automatic chk_pin(input string n, input logic x, input logic g);
    num_checks++;
    if (g !== x) fail(n, x, g);
  endtask : chk_pin
  task automatic chk_cyc(input string n, input int x, input int g);
    num_checks++;
    if (g != x) fail(n, x, g);
  endtask : chk_cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge core_clk_in);
    wr_in    <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge core_clk_in);
    rd_in   <= 1'b0;
    #1;
    v = rdata_out;
  endtask : rd
  task automatic wait_rises(input int n);
    int r0;
    r0 = rises;
    for (int i = 0; i < 20000 && rises < r0 + n; i++) @(posedge core_clk_in);
    if (rises < r0 + n) fail("pin rises", r0 + n, rises);
  endtask : wait_rises
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  // The ceiling leaves room over the slowest prescale sweep.
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(tpd_pkg::ADDR_DUTY, d);
    chk_reg("duty", 8'h00, d);
    chk_pin("gpio", 1'b1, pin_out);
    wr(tpd_pkg::ADDR_DUTY, 8'h5a);
    wr(8'h00, 8'hff);
    rd(tpd_pkg::ADDR_DUTY, d);
    chk_reg("duty", 8'h5a, d);
    rd(8'h00, d);
    chk_reg("hole", 8'h00, d);
    wr(tpd_pkg::ADDR_MODE, 8'h04);
    wr(tpd_pkg::ADDR_COUNT, 8'hf0);
    wr(tpd_pkg::ADDR_RELOAD, 8'hf0);
    wr(tpd_pkg::ADDR_DUTY, 8'hf4);
    wr(tpd_pkg::ADDR_STATUS, 8'h02);
    wr(tpd_pkg::ADDR_MODE, 8'h84);
    wr(tpd_pkg::ADDR_MODE, 8'h85);
    wait_rises(3);
    chk_cyc("period", 16, per);
    chk_cyc("high", 4, hi);
    chk_pin("oe", 1'b1, pin_oe_out);
    rd(tpd_pkg::ADDR_STATUS, d);
    chk_pin("flag", 1'b1, d[tpd_pkg::BIT_FLAG]);
    wr(tpd_pkg::ADDR_STATUS, 8'h03);
    chk_pin("irq", 1'b1, irq_out);
    wait_rises(1);
    wr(tpd_pkg::ADDR_RELOAD, 8'he0);
    wait_rises(1);
    chk_cyc("old period", 16, per);
    wait_rises(2);
    chk_cyc("new period", 32, per);
    for (int r = 7; r >= 0; r--) begin
      wr(tpd_pkg::ADDR_MODE, 8'(8'h81 | (r << 4)));
      wait_rises(2);
      chk_cyc("rate period", 32 << (7 - r), per);
    end
    wr(tpd_pkg::ADDR_MODE, 8'h85);
    wr(tpd_pkg::ADDR_RELOAD, 8'h00);
    wr(tpd_pkg::ADDR_DUTY, 8'h80);
    wait_rises(3);
    chk_cyc("full period", 256, per);
    chk_cyc("full high", 128, hi);
    wr(tpd_pkg::ADDR_DUTY, 8'h00);
    repeat (300) @(posedge core_clk_in);
    d = 8'(rises);
    repeat (600) @(posedge core_clk_in);
    #1;
    chk_reg("no pulse", d, 8'(rises));
    chk_pin("low", 1'b0, pin_out);
    wr(tpd_pkg::ADDR_MODE, 8'h84);
    chk_pin("gpio", 1'b1, pin_out);
    chk_pin("gpio oe", 1'b0, pin_oe_out);
    rd(tpd_pkg::ADDR_COUNT, d);
    rd(tpd_pkg::ADDR_COUNT, e);
    chk_pin("counting", 1'b1, d !== e);
    wr(tpd_pkg::ADDR_MODE, 8'h05);
    wr(tpd_pkg::ADDR_STATUS, 8'h02);
    rd(tpd_pkg::ADDR_COUNT, d);
    repeat (300) @(posedge core_clk_in);
    rd(tpd_pkg::ADDR_COUNT, e);
    chk_reg("held", d, e);
    chk_pin("off pin", 1'b0, pin_out);
    rd(tpd_pkg::ADDR_STATUS, d);
    chk_reg("status", 8'h02, d);
    chk_pin("irq", 1'b0, irq_out);
    summarize();
  end
endmodule : tpd_timer_tb_top
